// ### include/p7m_pkg.sv
// Package with register map, field layout and encodings of the port-7 pin-function mux.
package p7m_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ------------------------------------------------------------
    localparam logic [11:0] P7M_CTRL0_OFF = 12'h000; // Pin control, bits 0..3.
    localparam logic [11:0] P7M_CTRL1_OFF = 12'h004; // Pin control, bit 4.
    localparam logic [11:0] P7M_OUT_OFF = 12'h008;   // General-purpose output data.
    localparam logic [11:0] P7M_IN_OFF = 12'h00c;    // Synchronised pin levels.
    localparam logic [11:0] P7M_STRAP_OFF = 12'h010; // Captured start-up state.

    // ------------------------------------------------------------
    // Field layout and values
    // ------------------------------------------------------------
    localparam int P7M_NPINS = 5;
    localparam int P7M_SEL_W = 4;
    localparam int P7M_SEL_STRIDE = 8;            // Each pin's field sits in its own byte.
    localparam int P7M_SEL_OUTEN_BIT = 3;         // Field value 1x00 means output enabled.
    localparam logic [3:0] P7M_SEL_RESET = 4'h0;  // All pins start as inputs.
    localparam logic [4:0] P7M_OUT_RESET = 5'h00;
    localparam logic [1:0] P7M_ALT0 = 2'h0;       // Output selection zero.
    localparam logic [1:0] P7M_ALT1 = 2'h1;       // Output selection one.
    localparam logic [1:0] P7M_ALT2 = 2'h2;
    localparam logic [1:0] P7M_ALT3 = 2'h3;

    // ------------------------------------------------------------
    // Start-up debug position encodings
    // ------------------------------------------------------------
    localparam logic [1:0] P7M_DBGPOS_0 = 2'h0;
    localparam logic [1:0] P7M_DBGPOS_2 = 2'h2;
    localparam int P7M_STRAP_DBG_BIT = 0;
    localparam int P7M_STRAP_SCANC_BIT = 1;
    localparam int P7M_STRAP_POS_LSB = 2;
    localparam int P7M_STRAP_TEST_BIT = 4;

endpackage

// ### hdl/p7m_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/1ps
module p7m_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage, keeping metastability contained.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // p7m_sync

// ### hdl/p7m_mux.sv
// Port-7 pin-function multiplexer with APB register file and start-up capture.
//
// Function
// - Pin output picks output zero at 1x00, one at 1x01, onward by low bits.
// - Hardware-driven outputs bypass the software output select field.
// - Debug reset sampled at power-on reset release; high activates debug system.
// - Bit2: GP data at zero, analog mux bit0 at one; scan data in.
// - Bit0: GP, timer3, timer6 toggles; hardware test data out and debug data.
// - Bit0 also feeds service request 2 trigger input 1.
// - Bit3: GP, mux bit1, serial ch1, ch0 data out; feeds ch1 input, TMS.
// - Bit1: GP data or programmable clock; feeds debug break input C.
// - Bit4: GP, mux bit2, ch1 data, ch1 clock; feeds ch0, ch1, test clock.
// - Scan position C enables pull-up on bit2 test data input.
// - Bit4 pull-up with scan position C, else pull-down with debug position 2.
// - Scan position C enables a pull on bit3; polarity taken as pull-up.
`timescale 1ns/1ps
module p7m_mux
    import p7m_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Start-up straps and test pins
    input wire logic factory_test_enable_i,
    input wire logic debug_reset_i,
    input wire logic scan_pos_c_i,
    input wire logic [1:0] debug_pos_i,
    output logic debug_active_o,
    output logic factory_test_mode_o,
    // Peripheral outputs toward the pins
    input wire logic adc1_mux_ctrl_bit0_i,
    input wire logic adc1_mux_ctrl_bit1_i,
    input wire logic adc1_mux_ctrl_bit2_i,
    input wire logic timer3_toggle_out_i,
    input wire logic timer6_toggle_out_i,
    input wire logic serial_ch1_data_out_i,
    input wire logic serial_ch0_data_out_i,
    input wire logic serial_ch1_clock_out_i,
    input wire logic programmable_clock_out_i,
    input wire logic dbg_tdo_i,
    input wire logic dbg_tdo_en_i,
    // Pins, five signals each; output enable is low while driving
    input wire logic [4:0] pin_i,
    output logic [4:0] pin_o,
    output logic [4:0] pin_oen_o,
    output logic [4:0] pull_up_o,
    output logic [4:0] pull_down_o,
    // Alternate inputs toward peripherals
    output logic service_request2_trigger1_o,
    output logic serial_ch1_data_in_f_o,
    output logic serial_ch0_data_in_d_o,
    output logic serial_ch1_clock_in_e_o,
    output logic debug_break_in_pos_c_o,
    output logic scan_tdi_o,
    output logic scan_tms_o,
    output logic scan_tck_o,
    output logic dbg_data_in_o
);
    import p7m_pkg::*;

    // ------------------------------------------------------------
    // Registers and synchronised inputs
    // ------------------------------------------------------------
    logic [3:0] sel_q [P7M_NPINS];
    logic [4:0] out_q;
    logic [4:0] pin_s;
    logic [4:0] pin_s_q;
    logic [4:0] strap_s;
    logic por_done_q;
    logic [1:0] por_arm_q;
    logic dbg_q;
    logic scanc_q;
    logic [1:0] pos_q;
    logic test_q;

    p7m_sync #(.W(5)) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_i(pin_i),
        .sync_o(pin_s)
    );

    p7m_sync #(.W(5)) u_strap_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_i({factory_test_enable_i, debug_pos_i, scan_pos_c_i, debug_reset_i}),
        .sync_o(strap_s)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire hit_c0 = paddr == P7M_CTRL0_OFF;
    wire hit_c1 = paddr == P7M_CTRL1_OFF;
    wire hit_out = paddr == P7M_OUT_OFF;
    wire hit_in = paddr == P7M_IN_OFF;
    wire hit_st = paddr == P7M_STRAP_OFF;
    wire mapped = hit_c0 | hit_c1 | hit_out | hit_in | hit_st;
    wire [4:0] strap_word = {test_q, pos_q, scanc_q, dbg_q};

    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0;
        for (int i = 0; i < 4; i++) begin
            if (hit_c0) begin
                rd_d[i*P7M_SEL_STRIDE +: P7M_SEL_W] = sel_q[i];
            end
        end
        if (hit_c1) begin
            rd_d[P7M_SEL_W-1:0] = sel_q[4];
        end
        if (hit_out) begin
            rd_d[4:0] = out_q;
        end
        if (hit_in) begin
            rd_d[4:0] = pin_s_q;
        end
        if (hit_st) begin
            rd_d[4:0] = strap_word;
        end
    end

    // Zero-wait slave: pready is asserted in every access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel & ~penable & ~pwrite) ? rd_d : prdata;
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // Control registers; writes to unmapped offsets are dropped with an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < P7M_NPINS; i++) begin
                sel_q[i] <= P7M_SEL_RESET;
            end
            out_q <= P7M_OUT_RESET;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr & hit_c0) begin
                    sel_q[i] <= pwdata[i*P7M_SEL_STRIDE +: P7M_SEL_W];
                end
            end
            if (wr & hit_c1) begin
                sel_q[4] <= pwdata[P7M_SEL_W-1:0];
            end
            if (wr & hit_out) begin
                out_q <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Start-up capture
    // ------------------------------------------------------------
    // Straps are taken once, when the synchroniser shows pin levels and not its reset zeros.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_arm_q <= 2'b00;
            por_done_q <= 1'b0;
            dbg_q <= 1'b0;
            scanc_q <= 1'b0;
            pos_q <= 2'h0;
            test_q <= 1'b0;
        end else begin
            por_arm_q <= {por_arm_q[0], 1'b1};
            if (por_arm_q[1] && !por_done_q) begin
                por_done_q <= 1'b1;
                dbg_q <= strap_s[P7M_STRAP_DBG_BIT];
                scanc_q <= strap_s[P7M_STRAP_SCANC_BIT];
                pos_q <= strap_s[P7M_STRAP_POS_LSB +: 2];
                test_q <= ~strap_s[P7M_STRAP_TEST_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Output selection per pin
    // ------------------------------------------------------------
    // Alternate output tables; a slot with no function drives low.
    logic [3:0] alt_tbl [P7M_NPINS];
    assign alt_tbl[0] = {1'b0, timer6_toggle_out_i, timer3_toggle_out_i, out_q[0]};
    assign alt_tbl[1] = {2'b00, programmable_clock_out_i, out_q[1]};
    assign alt_tbl[2] = {2'b00, adc1_mux_ctrl_bit0_i, out_q[2]};
    assign alt_tbl[3] = {serial_ch0_data_out_i, serial_ch1_data_out_i,
                         adc1_mux_ctrl_bit1_i, out_q[3]};
    assign alt_tbl[4] = {serial_ch1_clock_out_i, serial_ch1_data_out_i,
                         adc1_mux_ctrl_bit2_i, out_q[4]};

    logic [4:0] pin_d;
    logic [4:0] drv_d;
    genvar g;
    generate
        for (g = 0; g < P7M_NPINS; g++) begin : g_pin
            wire [1:0] alt = sel_q[g][1:0];
            assign pin_d[g] = alt_tbl[g][alt];
            assign drv_d[g] = sel_q[g][P7M_SEL_OUTEN_BIT];
        end
    endgenerate

    // Debug hardware owns bit 0 while active with dbg_tdo_en_i high, regardless of the select field.
    wire hw_own0 = dbg_q & dbg_tdo_en_i;
    wire [4:0] pin_f = {pin_d[4:1], hw_own0 ? dbg_tdo_i : pin_d[0]};
    wire [4:0] drv_f = {drv_d[4:1], drv_d[0] | hw_own0};

    // Pull devices from the captured start-up positions.
    wire dpos02 = dbg_q & ((pos_q == P7M_DBGPOS_0) | (pos_q == P7M_DBGPOS_2));
    wire dpos2 = dbg_q & (pos_q == P7M_DBGPOS_2);
    wire [4:0] pu_d = {scanc_q, scanc_q, scanc_q, 2'b00};
    wire [4:0] pd_d = {dpos2 & ~scanc_q, 3'b000, dpos02};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_o <= 5'h00;
            pin_oen_o <= 5'h1f;
            pull_up_o <= 5'h00;
            pull_down_o <= 5'h00;
            pin_s_q <= 5'h00;
            debug_active_o <= 1'b0;
            factory_test_mode_o <= 1'b0;
        end else begin
            pin_o <= pin_f;
            pin_oen_o <= ~drv_f;
            pull_up_o <= pu_d;
            pull_down_o <= pd_d;
            pin_s_q <= pin_s;
            debug_active_o <= dbg_q;
            factory_test_mode_o <= test_q;
        end
    end

    // ------------------------------------------------------------
    // Alternate inputs
    // ------------------------------------------------------------
    // Inputs read the synchronised pin, so output selection never blocks them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            service_request2_trigger1_o <= 1'b0;
            serial_ch1_data_in_f_o <= 1'b0;
            serial_ch0_data_in_d_o <= 1'b0;
            serial_ch1_clock_in_e_o <= 1'b0;
            debug_break_in_pos_c_o <= 1'b0;
            scan_tdi_o <= 1'b0;
            scan_tms_o <= 1'b0;
            scan_tck_o <= 1'b0;
            dbg_data_in_o <= 1'b0;
        end else begin
            service_request2_trigger1_o <= pin_s[0];
            serial_ch1_data_in_f_o <= pin_s[3];
            serial_ch0_data_in_d_o <= pin_s[4];
            serial_ch1_clock_in_e_o <= pin_s[4];
            debug_break_in_pos_c_o <= pin_s[1];
            scan_tdi_o <= pin_s[2] & scanc_q;
            scan_tms_o <= pin_s[3] & scanc_q;
            scan_tck_o <= pin_s[4] & scanc_q;
            dbg_data_in_o <= pin_s[0] & dbg_q;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_sel_drive;
        @(posedge pclk) disable iff (!presetn)
        (sel_q[1][P7M_SEL_OUTEN_BIT] && sel_q[1][1:0] == P7M_ALT1) |=>
            (!pin_oen_o[1] && pin_o[1] == $past(programmable_clock_out_i));
    endproperty
    a_sel_drive: assert property (p_sel_drive) else $error("bit1 select one wrong");

    property p_sel_off;
        @(posedge pclk) disable iff (!presetn)
        (sel_q[3][3] == 1'b0) |=> pin_oen_o[3];
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("pin driven while unselected");

    property p_hw_own;
        @(posedge pclk) disable iff (!presetn)
        hw_own0 |=> (!pin_oen_o[0] && pin_o[0] == $past(dbg_tdo_i));
    endproperty
    a_hw_own: assert property (p_hw_own) else $error("debug output not in control");

    property p_srq;
        @(posedge pclk) disable iff (!presetn)
        $rose(pin_i[0]) |-> ##3 service_request2_trigger1_o;
    endproperty
    a_srq: assert property (p_srq) else $error("trigger input lags pin");

    property p_ch0_in;
        @(posedge pclk) disable iff (!presetn)
        $fell(pin_i[4]) |-> ##3 (!serial_ch0_data_in_d_o && !serial_ch1_clock_in_e_o);
    endproperty
    a_ch0_in: assert property (p_ch0_in) else $error("bit4 inputs lag pin");

    property p_pu_c;
        @(posedge pclk) disable iff (!presetn)
        (por_done_q && scanc_q) |=> (pull_up_o[2] && pull_up_o[3] && pull_up_o[4]);
    endproperty
    a_pu_c: assert property (p_pu_c) else $error("position C pulls missing");

    property p_pd0;
        @(posedge pclk) disable iff (!presetn)
        (dbg_q && pos_q == P7M_DBGPOS_0) |=> pull_down_o[0];
    endproperty
    a_pd0: assert property (p_pd0) else $error("bit0 pull-down missing");

    property p_pd4;
        @(posedge pclk) disable iff (!presetn)
        (dbg_q && pos_q == P7M_DBGPOS_2 && !scanc_q) |=> (pull_down_o[4] && !pull_up_o[4]);
    endproperty
    a_pd4: assert property (p_pd4) else $error("bit4 pull wrong");

    property p_dbg_hold;
        @(posedge pclk) disable iff (!presetn)
        por_done_q |=> $stable(dbg_q);
    endproperty
    a_dbg_hold: assert property (p_dbg_hold) else $error("debug strap changed");

    c_apb_wr: cover property (@(posedge pclk) disable iff (!presetn) wr && hit_c0);
    c_hw_own: cover property (@(posedge pclk) disable iff (!presetn) hw_own0);
    c_scan_c: cover property (@(posedge pclk) disable iff (!presetn) scanc_q && por_done_q);
endmodule // p7m_mux

// ### test/p7m_board_model.sv
// Board-side model that resolves the level of each port-7 pin.
`timescale 1ns/1ps
module p7m_board_model (
    // Clock
    input wire logic pclk,
    // Device pad controls
    input wire logic [4:0] pin_o,
    input wire logic [4:0] pin_oen_o,
    input wire logic [4:0] pull_up_o,
    input wire logic [4:0] pull_down_o,
    // Board drivers
    input wire logic [4:0] board_val,
    input wire logic [4:0] board_en,
    // Resolved levels
    output logic [4:0] pin_lvl
);
    logic [4:0] last_q;
    // Device drive wins, then the board, then the pulls.
    // A floating pin flips every cycle, so no stale level can pass for a real one.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_lvl[i] = !pin_oen_o[i] ? pin_o[i] : board_en[i] ? board_val[i] :
                pull_up_o[i] ? 1'b1 : pull_down_o[i] ? 1'b0 : ~last_q[i];
        end
    end
    // Remember the last level for the floating case.
    always_ff @(posedge pclk) begin
        last_q <= pin_lvl;
    end
endmodule // p7m_board_model

// ### test/testbench.sv
// Self-checking testbench for the port-7 pin-function mux.
`timescale 1ns/1ps
module testbench;
    import p7m_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic ften = 1'b1, dbg_rst = 1'b0, scanc = 1'b0, tdo_en = 1'b0, dbg_act, ftm;
    logic [1:0] dpos = 2'h0;
    logic [9:0] per = 10'h000;
    logic [4:0] lvl, pin_o, pin_oen, pu, pd, brd_val = 5'h00, brd_en = 5'h1f;
    wire [8:0] alt;
    int errors = 0;
    int checks = 0;

    p7m_mux dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .factory_test_enable_i(ften), .debug_reset_i(dbg_rst),
        .scan_pos_c_i(scanc), .debug_pos_i(dpos), .debug_active_o(dbg_act),
        .factory_test_mode_o(ftm), .adc1_mux_ctrl_bit0_i(per[0]),
        .adc1_mux_ctrl_bit1_i(per[1]), .adc1_mux_ctrl_bit2_i(per[2]),
        .timer3_toggle_out_i(per[3]), .timer6_toggle_out_i(per[4]),
        .serial_ch1_data_out_i(per[5]), .serial_ch0_data_out_i(per[6]),
        .serial_ch1_clock_out_i(per[7]), .programmable_clock_out_i(per[8]),
        .dbg_tdo_i(per[9]), .dbg_tdo_en_i(tdo_en), .pin_i(lvl), .pin_o(pin_o),
        .pin_oen_o(pin_oen), .pull_up_o(pu), .pull_down_o(pd),
        .service_request2_trigger1_o(alt[0]), .serial_ch1_data_in_f_o(alt[1]),
        .serial_ch0_data_in_d_o(alt[2]), .serial_ch1_clock_in_e_o(alt[3]),
        .debug_break_in_pos_c_o(alt[4]), .scan_tdi_o(alt[5]), .scan_tms_o(alt[6]),
        .scan_tck_o(alt[7]), .dbg_data_in_o(alt[8]));

    p7m_board_model board_u (.pclk(pclk), .pin_o(pin_o), .pin_oen_o(pin_oen),
        .pull_up_o(pu), .pull_down_o(pd), .board_val(brd_val), .board_en(brd_en),
        .pin_lvl(lvl));

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    // Verdict and end of run.
    task automatic close_out();
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One comparison, counted.
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Let n edges pass, then step off the edge so outputs have settled.
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 32'(pready), 32'h1);
            close_out();
        end
    endtask

    // Reset with the given start-up straps, held past the release.
    task automatic do_reset(input logic dbg, input logic sc, input logic [1:0] pos,
        input logic ten);
        @(posedge pclk);
        presetn <= 1'b0;
        dbg_rst <= dbg;
        scanc <= sc;
        dpos <= pos;
        ften <= ten;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wait_n(5);
    endtask

    // Captured start-up state and the pulls it implies.
    task automatic check_straps(input logic [4:0] s, input logic [4:0] up,
        input logic [4:0] dn);
        chk("debug_active", 32'(dbg_act), 32'(s[0]));
        chk("test_mode", 32'(ftm), 32'(s[4]));
        chk("pull_up", 32'(pu), 32'(up));
        chk("pull_down", 32'(pd), 32'(dn));
        chk("pin_oen", 32'(pin_oen), 32'h1f);
        apb(1'b0, P7M_STRAP_OFF, 32'h0);
        chk("strap_reg", rd, 32'(s));
    endtask

    function automatic logic [8:0] alt_exp(input logic [4:0] l);
        return {l[0], l[4], l[3], l[2], l[1], l[4], l[4], l[3], l[0]};
    endfunction

    // Debug activation at start-up; the debugger then drives its reset low and leaves it low.
    task automatic t_startup_a();
        do_reset(1'b1, 1'b1, P7M_DBGPOS_2, 1'b1);
        check_straps(5'h0b, 5'h1c, 5'h01);
        @(posedge pclk);
        dbg_rst <= 1'b0;
        wait_n(3);
        chk("debug_active", 32'(dbg_act), 32'h1);
    endtask

    // Read-back, read-only and unmapped accesses.
    task automatic t_regs();
        apb(1'b1, P7M_STRAP_OFF, 32'h1f);
        apb(1'b0, P7M_STRAP_OFF, 32'h0);
        chk("strap_ro", rd, 32'h0b);
        apb(1'b1, P7M_CTRL0_OFF, 32'h0b0a0908);
        apb(1'b0, P7M_CTRL0_OFF, 32'h0);
        chk("ctrl0", rd, 32'h0b0a0908);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
    endtask

    // Every pin through every output selection, with both levels on each source.
    task automatic t_select();
        int src [20] = '{10, 3, 4, 11, 10, 8, 11, 11, 10, 0, 11, 11, 10, 1, 5, 6, 10, 2, 5, 7};
        logic [4:0] g;
        logic [3:0] s;
        logic [11:0] v;
        for (int k = 0; k < 2; k++) begin
            g = k ? 5'h0a : 5'h15;
            apb(1'b1, P7M_OUT_OFF, 32'(g));
            for (int p = 0; p < 5; p++) begin
                for (int a = 0; a < 4; a++) begin
                    s = {1'b1, 1'(p), 2'(a)};
                    apb(1'b1, p < 4 ? P7M_CTRL0_OFF : P7M_CTRL1_OFF, 32'(s) << (8 * (p % 4)));
                    for (int j = 0; j < 2; j++) begin
                        @(posedge pclk);
                        per <= j ? 10'h2aa : 10'h155;
                        wait_n(2);
                        v = {1'b0, g[p], j ? 10'h2aa : 10'h155};
                        chk("pin_o", 32'(pin_o[p]), 32'(v[src[4*p+a]]));
                        chk("pin_oen", 32'(pin_oen[p]), 32'h0);
                    end
                end
            end
        end
    endtask

    // Debug hardware owns pin 0 while its select field picks the timer3 toggle.
    task automatic t_hw();
        apb(1'b1, P7M_CTRL0_OFF, 32'h9);
        for (int j = 0; j < 2; j++) begin
            @(posedge pclk);
            tdo_en <= 1'b1;
            per <= j ? 10'h008 : 10'h200;
            wait_n(2);
            chk("pin0_hw", {pin_o[0], pin_oen[0]}, j ? 32'h0 : 32'h2);
        end
        @(posedge pclk);
        tdo_en <= 1'b0;
    endtask

    // Alternate inputs follow the pin, driven by the board or by the device.
    task automatic t_alt();
        apb(1'b1, P7M_CTRL0_OFF, 32'h0);
        apb(1'b1, P7M_CTRL1_OFF, 32'h0);
        wait_n(2);
        chk("pin_oen", 32'(pin_oen), 32'h1f);
        for (int j = 0; j < 3; j++) begin
            @(posedge pclk);
            brd_val <= j[0] ? 5'h0a : 5'h15;
            brd_en <= j == 2 ? 5'h00 : 5'h1f;
            if (j == 2) begin
                apb(1'b1, P7M_OUT_OFF, 32'h16);
                apb(1'b1, P7M_CTRL0_OFF, 32'h08080808);
                apb(1'b1, P7M_CTRL1_OFF, 32'h8);
            end
            wait_n(5);
            chk("alt_in", 32'(alt), 32'(alt_exp(j == 2 ? 5'h16 : brd_val)));
            apb(1'b0, P7M_IN_OFF, 32'h0);
            chk("in_reg", rd, 32'(j == 2 ? 5'h16 : brd_val));
        end
    endtask

    // Other start-up choices: test mode, debug off, debug position 0.
    task automatic t_startup_bc();
        do_reset(1'b1, 1'b0, P7M_DBGPOS_0, 1'b0);
        check_straps(5'h11, 5'h00, 5'h01);
        @(posedge pclk);
        brd_val <= 5'h1f;
        brd_en <= 5'h1f;
        do_reset(1'b1, 1'b0, P7M_DBGPOS_2, 1'b1);
        check_straps(5'h09, 5'h00, 5'h11);
        do_reset(1'b0, 1'b0, P7M_DBGPOS_2, 1'b1);
        check_straps(5'h08, 5'h00, 5'h00);
        wait_n(3);
        chk("alt_gated", 32'(alt), 32'h01f);
    endtask

    // Main sequence.
    initial begin
        t_startup_a();
        t_regs();
        t_select();
        t_hw();
        t_alt();
        t_startup_bc();
        close_out();
    end
endmodule // testbench
